// File: hdl/cmmc_mode_ctrl.sv
// command and power mode control of one stack cell monitor
// assumes command words come decoded from the serial front end as address reads,
// clock edges and chain ticks as one-cycle pulses on the core clock
// Behaviour
// R1 - command reads at set addresses are commands
// R2 - addresses 01 to 05 zero suffix: scans
// R3 - address 06 starts repeated interval scanning
// R4 - address 08 measures element in suffix
// R5 - busy device ignores new scan commands
// R6 - ignored commands still go up the chain
// R7 - other commands work while scanning
// R8 - sleep on command or watchdog expiry
// R9 - sleep keeps timed scans, wakes on traffic
// R10 - enable low means shutdown, core stays up
// R11 - leaving shutdown reloads no factory data
// R12 - normal mode: standby waits, active converts
// R13 - up to 14 devices, bottom is one
// R14 - middles are two to n-1
// R15 - bottom uses spi, middles two ports
// R16 - chained results carry position tags
// R17 - read-all address streams all data
// R18 - addressed, top, bottom own the timing
// R19 - no filtering on converter results
// R20 - start at 24th or 16th falling edge
// R21 - continuous flag set, cleared by inhibit
// R22 - one chain tick start lag per device
// R23 - undefined address changes no state; code still updates tmaster
`timescale 1ns/1ps
module cmmc_mode_ctrl #(
   parameter int INTV_W = 20,
   parameter logic [5:0] READ_ALL_ADDR = 6'h3f,
   parameter int BUF_DEPTH = 2
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_cmd_valid,
   input wire logic [5:0] i_cmd_addr,
   input wire logic [5:0] i_cmd_suffix,
   input wire logic [3:0] i_cmd_target,
   input wire logic i_cmd_bcast,
   output logic o_cmd_ready,
   output logic o_fwd_valid,
   input wire logic i_fwd_ready,
   output logic [5:0] o_fwd_addr,
   output logic [5:0] o_fwd_suffix,
   output logic [3:0] o_fwd_target,
   output logic o_fwd_bcast,
   input wire logic [3:0] i_dev_position,
   input wire logic [3:0] i_stack_size,
   input wire logic i_frame_start,
   input wire logic i_cmd_clk_fall,
   input wire logic i_chain_tick,
   input wire logic i_enable,
   input wire logic i_sleep_cmd,
   input wire logic i_wdog_expire,
   input wire logic i_comm_wake,
   input wire logic i_scan_inhibit,
   input wire logic i_scan_done,
   input wire logic [INTV_W-1:0] i_scan_interval,
   output logic o_scan_start,
   output cmmc_pkg::cmmc_kind_t o_scan_kind,
   output logic [5:0] o_meas_elem,
   output logic o_scan_busy,
   output logic o_cont_scan,
   output logic o_cmd_ignored,
   output logic o_read_all,
   output logic o_other_cmd,
   output logic [5:0] o_other_addr,
   output logic [5:0] o_other_suffix,
   output cmmc_pkg::cmmc_pwr_t o_power_state,
   output logic o_analog_en,
   output logic o_fast_osc_en,
   output logic o_slow_osc_en,
   output logic o_core_en,
   output logic o_comm_in_en,
   output logic o_nvm_reload,
   output logic o_role_solo,
   output logic o_role_bottom,
   output logic o_role_middle,
   output logic o_role_top,
   output logic o_pos_error,
   output logic o_spi_en,
   output logic o_up_port_en,
   output logic o_down_port_en,
   output logic o_timing_master,
   output logic o_tag_results,
   output logic o_adc_filter_en,
   output logic o_fault_filter_en
);
   localparam logic [INTV_W-1:0] INTV_ONE = {{(INTV_W-1){1'b0}}, 1'b1};

   // whole state of the mode control
   typedef struct packed {
      cmmc_pkg::cmmc_pwr_t pstate; // power state
      logic ret_sleep; // timed scan began in sleep
      logic scan_flag; // continuous scanning on
      logic pend; // accepted command waits to start
      cmmc_pkg::cmmc_kind_t pend_kind; // kind of waiting command
      logic sync_hit; // start edge of this frame seen
      logic [4:0] sync_cnt; // falling edges in this frame
      logic lat_run; // stack lag countdown running
      logic [3:0] lat_cnt; // chain ticks still to wait
      logic [INTV_W-1:0] intv; // cycles to next timed scan
      cmmc_pkg::cmmc_kind_t cur_kind; // kind of running scan
      logic [5:0] meas_elem; // element of a measure
      logic start_p; // scan start pulse
      logic ign_p; // ignored command pulse
      logic rd_all_p; // read-all pulse
      logic other_p; // other command pulse
      logic [5:0] other_addr; // its address
      logic [5:0] other_suffix; // its suffix
      logic booted; // first cycle after reset done
      logic reload_p; // factory reload pulse
      logic solo; // single device, no chain
      logic bottom; // chain position one
      logic middle; // between bottom and top
      logic top; // last in chain
      logic pos_err; // position or size out of range
      logic tmaster; // last command for this device addressed it alone, not by broadcast
   } cmmc_st_t;

   cmmc_st_t s; // registered state
   cmmc_st_t next_s; // next state
   cmmc_pkg::cmmc_kind_t kind; // decoded kind of offered command
   logic take; // command leaves the buffer
   logic fwd_need; // device has a port above
   logic addressed; // command is for this device
   logic busy; // scan running or waiting
   logic go; // a scan starts now
   logic tmr_go; // interval timer starts a scan
   logic [4:0] sync_target; // falling edge that starts a scan
   logic [5:0] c_addr; // unpacked fields
   logic [5:0] c_sfx;
   logic [3:0] c_tgt;
   logic c_bc;

   cmmc_cmd_if #(.W(cmmc_pkg::CMD_W)) cmd();

   // input buffer holds words while the chain above stalls
   cmmc_cmd_buf #(.W(cmmc_pkg::CMD_W), .DEPTH(BUF_DEPTH)) u_buf (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_valid(i_cmd_valid),
      .i_data({i_cmd_bcast, i_cmd_target, i_cmd_suffix, i_cmd_addr}),
      .o_ready(o_cmd_ready),
      .out(cmd)
   );

   assign {c_bc, c_tgt, c_sfx, c_addr} = cmd.data;

   // address and suffix classification
   cmmc_cmd_decode u_dec (
      .i_addr(c_addr),
      .i_suffix(c_sfx),
      .o_kind(kind)
   );

   // every command is repeated upward unless this is the top device or a single device
   assign fwd_need = !s.top && !s.solo; // see R6
   assign cmd.ready = cmd.valid && (!fwd_need || i_fwd_ready); // see R6
   assign take = cmd.valid && cmd.ready;
   assign o_fwd_valid = cmd.valid && fwd_need; // see R6
   assign o_fwd_addr = c_addr;
   assign o_fwd_suffix = c_sfx;
   assign o_fwd_target = c_tgt;
   assign o_fwd_bcast = c_bc;
   assign addressed = c_bc || (c_tgt == i_dev_position);
   assign busy = (s.pstate == cmmc_pkg::PWR_ACTIVE) || s.pend; // see R5
   assign sync_target = s.solo ? cmmc_pkg::SYNC_PULSE_SOLO : cmmc_pkg::SYNC_PULSE_CHAIN;
   // timed scans run from standby and from sleep alike
   assign tmr_go = s.scan_flag && (s.intv == '0) && !s.pend &&
      ((s.pstate == cmmc_pkg::PWR_STANDBY) || (s.pstate == cmmc_pkg::PWR_SLEEP)); // see R9
   assign go = (s.lat_run && (s.lat_cnt == 4'h0)) || tmr_go;

   // next state
   always_comb begin
      next_s = s;
      next_s.start_p = 1'b0;
      next_s.ign_p = 1'b0;
      next_s.rd_all_p = 1'b0;
      next_s.other_p = 1'b0;
      next_s.reload_p = 1'b0;
      // factory data loads only once, after reset, never after shutdown
      next_s.booted = 1'b1;
      next_s.reload_p = !s.booted; // see R11
      // chain role from strapped position and stack size
      next_s.solo = (i_stack_size == cmmc_pkg::POS_BOTTOM); // see R13
      next_s.bottom = !next_s.solo && (i_dev_position == cmmc_pkg::POS_BOTTOM); // see R13
      next_s.top = !next_s.solo && (i_dev_position == i_stack_size); // see R13
      next_s.middle = !next_s.solo && (i_dev_position >= cmmc_pkg::POS_FIRST_MIDDLE) &&
         (i_dev_position < i_stack_size); // see R14
      next_s.pos_err = (i_dev_position == 4'h0) || (i_dev_position > i_stack_size) ||
         (i_stack_size > cmmc_pkg::MAX_DEVICES); // see R13
      // count falling command clock edges up to the start edge
      if (i_frame_start) begin
         next_s.sync_cnt = 5'h00;
         next_s.sync_hit = 1'b0;
      end else if (i_cmd_clk_fall && !s.sync_hit) begin
         next_s.sync_cnt = s.sync_cnt + 5'h01;
         next_s.sync_hit = ((s.sync_cnt + 5'h01) == sync_target); // see R20
      end
      // command taken from the buffer
      if (take && addressed) begin
         next_s.tmaster = !c_bc; // see R18
         if (cmmc_pkg::cmmc_is_meas(kind)) begin
            if (busy) begin
               // dropped here, still repeated upward
               next_s.ign_p = 1'b1; // see R5
            end else begin
               next_s.pend = 1'b1; // see R1
               next_s.pend_kind = kind; // see R2
               if (kind == cmmc_pkg::K_MEAS) begin
                  next_s.meas_elem = c_sfx; // see R4
               end
            end
         end else if (kind == cmmc_pkg::K_OTHER) begin
            // other functions answer regardless of scanning
            next_s.other_p = 1'b1; // see R7
            next_s.other_addr = c_addr;
            next_s.other_suffix = c_sfx;
            next_s.rd_all_p = (c_addr == READ_ALL_ADDR); // see R17
         end
         // undefined reads fall through and touch nothing but tmaster, see R23
      end
      // waiting command starts the stack lag on the start edge
      if (s.pend && s.sync_hit && !s.lat_run) begin
         next_s.lat_run = 1'b1;
         next_s.lat_cnt = s.solo ? 4'h0 : (i_dev_position - cmmc_pkg::POS_BOTTOM); // see R22
      end else if (s.lat_run && i_chain_tick && (s.lat_cnt != 4'h0)) begin
         next_s.lat_cnt = s.lat_cnt - 4'h1; // see R22
      end
      // interval countdown between continuous scans
      if (s.scan_flag && (s.intv != '0) && ((s.pstate == cmmc_pkg::PWR_STANDBY) ||
            (s.pstate == cmmc_pkg::PWR_SLEEP))) begin
         next_s.intv = s.intv - INTV_ONE; // see R3
      end
      // inhibit clears the flag; a timed or continuous start in the same cycle wins below
      if (i_scan_inhibit) begin
         next_s.scan_flag = 1'b0; // see R21
      end
      // power state machine
      if (!i_enable) begin
         // pin low: analog off, digital core stays up, pending scan and lag dropped
         next_s.pstate = cmmc_pkg::PWR_SHUTDOWN; // see R10
         next_s.pend = 1'b0;
         next_s.lat_run = 1'b0;
         next_s.ret_sleep = 1'b0;
      end else begin
         case (s.pstate)
            cmmc_pkg::PWR_SHUTDOWN: begin
               // power up straight to standby, no reload
               next_s.pstate = cmmc_pkg::PWR_STANDBY; // see R11
            end
            cmmc_pkg::PWR_ACTIVE: begin
               // conversion done: timed scans begun in sleep go back to sleep, all others to standby
               if (i_scan_done) begin
                  next_s.pstate = s.ret_sleep ? cmmc_pkg::PWR_SLEEP :
                     cmmc_pkg::PWR_STANDBY; // see R12
                  next_s.ret_sleep = 1'b0;
                  if (s.scan_flag) begin
                     next_s.intv = i_scan_interval; // see R3
                  end
               end
            end
            cmmc_pkg::PWR_STANDBY, cmmc_pkg::PWR_SLEEP: begin
               if (go) begin
                  next_s.pstate = cmmc_pkg::PWR_ACTIVE; // see R12
                  next_s.start_p = 1'b1;
                  next_s.ret_sleep = (s.pstate == cmmc_pkg::PWR_SLEEP) && tmr_go; // see R9
                  next_s.cur_kind = tmr_go ? cmmc_pkg::K_CONT : s.pend_kind;
                  if (!tmr_go) begin
                     next_s.pend = 1'b0;
                     next_s.lat_run = 1'b0;
                  end
                  if (tmr_go || (s.pend_kind == cmmc_pkg::K_CONT)) begin
                     next_s.scan_flag = 1'b1; // see R21
                  end
               end else if ((s.pstate == cmmc_pkg::PWR_STANDBY) &&
                     (i_sleep_cmd || i_wdog_expire)) begin
                  next_s.pstate = cmmc_pkg::PWR_SLEEP; // see R8
               end else if ((s.pstate == cmmc_pkg::PWR_SLEEP) && i_comm_wake) begin
                  next_s.pstate = cmmc_pkg::PWR_STANDBY; // see R9
               end
            end
            default: begin
               next_s.pstate = cmmc_pkg::PWR_STANDBY;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         s <= '0;
         s.pstate <= cmmc_pkg::PWR_STANDBY;
         s.pend_kind <= cmmc_pkg::K_NONE;
         s.cur_kind <= cmmc_pkg::K_NONE;
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign o_scan_start = s.start_p;
   assign o_scan_kind = s.cur_kind;
   assign o_meas_elem = s.meas_elem;
   assign o_scan_busy = (s.pstate == cmmc_pkg::PWR_ACTIVE);
   assign o_cont_scan = s.scan_flag;
   assign o_cmd_ignored = s.ign_p;
   assign o_read_all = s.rd_all_p;
   assign o_other_cmd = s.other_p;
   assign o_other_addr = s.other_addr;
   assign o_other_suffix = s.other_suffix;
   assign o_power_state = s.pstate;
   // in sleep only comms inputs, slow clock and the registers live
   assign o_analog_en = (s.pstate == cmmc_pkg::PWR_STANDBY) ||
      (s.pstate == cmmc_pkg::PWR_ACTIVE); // see R9
   assign o_fast_osc_en = o_analog_en; // see R9
   assign o_slow_osc_en = (s.pstate != cmmc_pkg::PWR_SHUTDOWN); // see R10
   assign o_core_en = 1'b1; // see R10
   assign o_comm_in_en = 1'b1; // see R10
   assign o_nvm_reload = s.reload_p;
   assign o_role_solo = s.solo;
   assign o_role_bottom = s.bottom;
   assign o_role_middle = s.middle;
   assign o_role_top = s.top;
   assign o_pos_error = s.pos_err;
   // ports used follow the chain position
   assign o_spi_en = s.solo || s.bottom; // see R15
   assign o_up_port_en = s.bottom || s.middle; // see R15
   assign o_down_port_en = s.middle || s.top; // see R15
   assign o_timing_master = s.solo || s.bottom || s.top || s.tmaster; // see R18
   assign o_tag_results = !s.solo; // see R16
   assign o_adc_filter_en = 1'b0; // see R19
   assign o_fault_filter_en = 1'b1; // see R19

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   sequence seq_meas_take;
      take && addressed && cmmc_pkg::cmmc_is_meas(kind);
   endsequence
   sequence seq_shutdown_exit;
      (s.pstate == cmmc_pkg::PWR_SHUTDOWN) ##1 (s.pstate != cmmc_pkg::PWR_SHUTDOWN);
   endsequence

   a_busy_ignore: assert property ((seq_meas_take and busy) |=> o_cmd_ignored && // see R5
      (s.pend_kind == $past(s.pend_kind)) && (o_meas_elem == $past(o_meas_elem)))
      else $error("busy command not ignored");
   a_fwd_stall: assert property ((o_fwd_valid && !i_fwd_ready) |=> o_fwd_valid && // see R6
      $stable({o_fwd_bcast, o_fwd_target, o_fwd_suffix, o_fwd_addr}))
      else $error("forwarded word dropped while chain stalled");
   a_meas_element: assert property ((seq_meas_take and !busy and // see R4
      (kind == cmmc_pkg::K_MEAS && i_enable)) |=> s.pend && (o_meas_elem == $past(c_sfx)))
      else $error("measure element not captured");
   a_undef_nothing: assert property ((take && kind == cmmc_pkg::K_UNDEF && !s.pend) // see R23
      |=> !s.pend && !o_other_cmd)
      else $error("undefined command had an effect");
   a_shutdown_pin: assert property (!i_enable |=> (s.pstate == cmmc_pkg::PWR_SHUTDOWN) // see R10
      && !o_analog_en && o_core_en)
      else $error("enable low did not shut down");
   a_no_reload: assert property (seq_shutdown_exit |-> !o_nvm_reload ##1 !o_nvm_reload) // see R11
      else $error("reload after shutdown exit");
   a_sleep_entry: assert property ((s.pstate == cmmc_pkg::PWR_STANDBY && i_enable && !go // see R8
      && (i_sleep_cmd || i_wdog_expire)) |=> s.pstate == cmmc_pkg::PWR_SLEEP)
      else $error("sleep not entered");
   a_sleep_wake: assert property ((s.pstate == cmmc_pkg::PWR_SLEEP && i_enable && !go // see R9
      && i_comm_wake) |=> s.pstate == cmmc_pkg::PWR_STANDBY)
      else $error("traffic did not wake");
   a_sync_edge: assert property ($rose(s.sync_hit) |-> s.sync_cnt == sync_target) // see R20
      else $error("start edge count wrong");
   a_cont_flag: assert property ((o_scan_start && o_scan_kind == cmmc_pkg::K_CONT) // see R21
      |-> o_cont_scan)
      else $error("continuous flag not set");
   a_done_standby: assert property ((s.pstate == cmmc_pkg::PWR_ACTIVE && i_scan_done // see R12
      && i_enable && !s.ret_sleep) |=> s.pstate == cmmc_pkg::PWR_STANDBY)
      else $error("scan end did not return to standby");
   a_role_single: assert property ($onehot0({s.solo, s.bottom, s.middle, s.top})) // see R14
      else $error("more than one chain role");
endmodule

// File: hdl/cmmc_pkg.sv
// constants, types and decode helpers of the cell monitor mode control
// assumes nothing beyond a SystemVerilog compiler; no imports anywhere
package cmmc_pkg;
   // measurement command addresses and the suffix they must carry
   localparam logic [5:0] ADDR_SCAN_VOLT = 6'h01;
   localparam logic [5:0] ADDR_SCAN_TEMP = 6'h02;
   localparam logic [5:0] ADDR_SCAN_MIXED = 6'h03;
   localparam logic [5:0] ADDR_SCAN_WIRES = 6'h04;
   localparam logic [5:0] ADDR_SCAN_ALL = 6'h05;
   localparam logic [5:0] ADDR_SCAN_CONT = 6'h06;
   localparam logic [5:0] ADDR_UNUSED_07 = 6'h07;
   localparam logic [5:0] ADDR_MEASURE = 6'h08;
   localparam logic [5:0] SUFFIX_NONE = 6'h00;
   // chain geometry
   localparam logic [3:0] MAX_DEVICES = 4'he;
   localparam logic [3:0] POS_BOTTOM = 4'h1;
   localparam logic [3:0] POS_FIRST_MIDDLE = 4'h2;
   // falling command clock edge that starts a scan
   localparam logic [4:0] SYNC_PULSE_CHAIN = 5'h18;
   localparam logic [4:0] SYNC_PULSE_SOLO = 5'h10;
   // command word layout: {broadcast, target, suffix, address}
   localparam int CMD_W = 17;
   // decoded command kinds
   typedef enum logic [3:0] {
      K_NONE, K_VOLT, K_TEMP, K_MIXED, K_WIRES, K_ALL, K_CONT, K_MEAS, K_UNDEF, K_OTHER
   } cmmc_kind_t;
   // power states
   typedef enum logic [1:0] {PWR_SHUTDOWN, PWR_SLEEP, PWR_STANDBY, PWR_ACTIVE} cmmc_pwr_t;
   // classify a command read by address and suffix
   function automatic cmmc_kind_t cmmc_decode(input logic [5:0] addr, input logic [5:0] sfx);
      cmmc_kind_t k;
      k = K_OTHER;
      case (addr)
         ADDR_SCAN_VOLT: k = (sfx == SUFFIX_NONE) ? K_VOLT : K_UNDEF;
         ADDR_SCAN_TEMP: k = (sfx == SUFFIX_NONE) ? K_TEMP : K_UNDEF;
         ADDR_SCAN_MIXED: k = (sfx == SUFFIX_NONE) ? K_MIXED : K_UNDEF;
         ADDR_SCAN_WIRES: k = (sfx == SUFFIX_NONE) ? K_WIRES : K_UNDEF;
         ADDR_SCAN_ALL: k = (sfx == SUFFIX_NONE) ? K_ALL : K_UNDEF;
         ADDR_SCAN_CONT: k = (sfx == SUFFIX_NONE) ? K_CONT : K_UNDEF;
         ADDR_MEASURE: k = K_MEAS;
         SUFFIX_NONE, ADDR_UNUSED_07: k = K_UNDEF;
         default: k = K_OTHER;
      endcase
      return k;
   endfunction
   // true for any scan or measure command
   function automatic logic cmmc_is_meas(input cmmc_kind_t k);
      return (k >= K_VOLT) && (k <= K_MEAS);
   endfunction
endpackage

// File: hdl/cmmc_cmd_if.sv
// valid/ready command carrier between the input buffer and the mode control
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface cmmc_cmd_if #(parameter int W = 17);
   logic valid; // a command word is offered
   logic ready; // the consumer takes it this cycle
   logic [W-1:0] data; // command word
   modport src(output valid, output data, input ready);
   modport dst(input valid, input data, output ready);
endinterface

// File: hdl/cmmc_cmd_buf.sv
// small fifo in the command path so a stalled chain loses no word
// assumes synchronous active-low reset and one clock
`timescale 1ns/1ps
module cmmc_cmd_buf #(
   parameter int W = 17,
   parameter int DEPTH = 2
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_ready,
   cmmc_cmd_if.src out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
   // whole buffer state
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem; // stored words
      logic [PW-1:0] wr; // write slot
      logic [PW-1:0] rd; // read slot
      logic [PW:0] cnt; // words held
   } cmmc_buf_st_t;
   cmmc_buf_st_t s;
   cmmc_buf_st_t next_s;
   logic push;
   logic pop;
   assign o_ready = (s.cnt != FULL);
   assign out.valid = (s.cnt != '0);
   assign out.data = s.mem[s.rd];
   assign push = i_valid && o_ready;
   assign pop = out.valid && out.ready;
   // pointer and count update
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = i_data;
         next_s.wr = (s.wr == LAST) ? '0 : s.wr + 1'b1;
      end
      if (pop) begin
         next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end
   // state register
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   a_buf_no_overrun: assert property (s.cnt <= FULL) else $error("buffer count overrun");
   a_buf_full_stall: assert property ((s.cnt == FULL && !out.ready) |=> !o_ready)
      else $error("full buffer offered ready");
endmodule

// File: hdl/cmmc_cmd_decode.sv
// classifies a command read into a scan, measure, undefined or other command
// assumes address and suffix are stable while the command is offered
`timescale 1ns/1ps
module cmmc_cmd_decode (
   input wire logic [5:0] i_addr,
   input wire logic [5:0] i_suffix,
   output cmmc_pkg::cmmc_kind_t o_kind
);
   // pure table lookup
   always_comb begin
      o_kind = cmmc_pkg::cmmc_decode(i_addr, i_suffix);
   end
endmodule

// File: verif/cmmc_up_model.sv
// upper chain neighbour and scan engine stand-in
// assumes one core clock; done is a one-cycle pulse
`timescale 1ns/1ps
module cmmc_up_model (
   input wire logic i_core_clk,
   input wire logic i_fwd_valid,
   input wire logic i_busy,
   output logic o_fwd_ready,
   output logic o_scan_done,
   output int o_taken
);
   int n = 0; // free cycle count, stalls every third cycle
   int d = 0; // cycles spent busy
   int cnt = 0; // words taken
   logic done = 0;
   assign o_fwd_ready = (n % 3) != 0;
   assign o_scan_done = done;
   assign o_taken = cnt;
   // take forwarded words, end each scan after 16 busy cycles
   always @(posedge i_core_clk) begin
      n <= n + 1;
      if (i_fwd_valid && o_fwd_ready) cnt <= cnt + 1;
      d <= i_busy ? d + 1 : 0;
      done <= i_busy && d == 15;
   end
endmodule

// File: verif/tb_top.sv
// self-checking bench of the mode control, bottom device of three
// assumes the chain model above answers forwarded words
`timescale 1ns/1ps
module tb_top;
   logic i_core_clk = 0, i_resetn = 0, i_cmd_valid = 0, i_cmd_bcast = 0, i_enable = 1;
   logic i_sleep_cmd = 0, i_wdog_expire = 0, i_comm_wake = 0, i_scan_inhibit = 0;
   logic i_frame_start = 0, i_cmd_clk_fall = 0, i_fwd_ready, i_scan_done;
   logic [5:0] i_cmd_addr = 6'h00, i_cmd_suffix = 6'h00, o_meas_elem;
   logic o_cmd_ready, o_fwd_valid, o_scan_start, o_scan_busy, o_cont_scan, o_cmd_ignored;
   logic o_core_en, o_nvm_reload, o_spi_en, o_up_port_en, o_down_port_en;
   logic o_tag_results, o_adc_filter_en, o_read_all;
   cmmc_pkg::cmmc_kind_t o_scan_kind;
   cmmc_pkg::cmmc_pwr_t o_power_state;
   int mismatches = 0, samples_checked = 0, taken, sent = 0;
   logic [15:0] rows [8] = '{{6'h01, 6'h00, 4'h1}, {6'h02, 6'h00, 4'h2},
      {6'h03, 6'h00, 4'h3}, {6'h04, 6'h00, 4'h4}, {6'h05, 6'h00, 4'h5},
      {6'h08, 6'h2a, 4'h7}, {6'h07, 6'h00, 4'h0}, {6'h01, 6'h01, 4'h0}};
   always #10 i_core_clk = ~i_core_clk;
   cmmc_mode_ctrl cmmc_mode_ctrl_inst (.i_core_clk, .i_resetn, .i_cmd_valid, .i_cmd_addr,
      .i_cmd_suffix, .i_cmd_target(4'h1), .i_cmd_bcast, .o_cmd_ready, .o_fwd_valid,
      .i_fwd_ready, .o_fwd_addr(), .o_fwd_suffix(), .o_fwd_target(), .o_fwd_bcast(),
      .i_dev_position(4'h1), .i_stack_size(4'h3), .i_frame_start, .i_cmd_clk_fall,
      .i_chain_tick(1'b0), .i_enable, .i_sleep_cmd, .i_wdog_expire, .i_comm_wake,
      .i_scan_inhibit, .i_scan_done, .i_scan_interval(20'h00008), .o_scan_start,
      .o_scan_kind, .o_meas_elem, .o_scan_busy, .o_cont_scan, .o_cmd_ignored, .o_read_all,
      .o_other_cmd(), .o_other_addr(), .o_other_suffix(), .o_power_state, .o_analog_en(),
      .o_fast_osc_en(), .o_slow_osc_en(), .o_core_en, .o_comm_in_en(), .o_nvm_reload,
      .o_role_solo(), .o_role_bottom(), .o_role_middle(), .o_role_top(), .o_pos_error(),
      .o_spi_en, .o_up_port_en, .o_down_port_en, .o_timing_master(), .o_tag_results,
      .o_adc_filter_en, .o_fault_filter_en());
   cmmc_up_model cmmc_up_model_inst (.i_core_clk, .i_fwd_valid(o_fwd_valid),
      .i_busy(o_scan_busy), .o_fwd_ready(i_fwd_ready), .o_scan_done(i_scan_done),
      .o_taken(taken));
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic logic sel(input int w);
      return w == 0 ? o_scan_start : w == 1 ? !o_scan_busy : w == 2 ? o_cmd_ignored :
         w == 3 ? o_cmd_ready : o_read_all;
   endfunction
   // bounded wait: 0 start, 1 idle, 2 ignored, 3 ready, 4 read-all
   task automatic await(input int w);
      int k = 0;
      while (sel(w) !== 1'b1 && k < 80) begin
         tick(1);
         k++;
      end
      if (k == 80) begin
         mismatches++;
         $display("[ERR] wait %0d expected 1 seen 0", w);
         tally_and_finish();
      end
   endtask
   // offer a word, held until an edge with ready high
   task automatic send(input logic [5:0] a, input logic [5:0] s);
      i_cmd_addr = a;
      i_cmd_suffix = s;
      i_cmd_valid = 1;
      await(3);
      tick(1);
      i_cmd_valid = 0;
      sent++;
   endtask
   task automatic pulse(ref logic p);
      p = 1;
      tick(1);
      p = 0;
   endtask
   // frame start then 24 falling command clock edges
   task automatic sync();
      pulse(i_frame_start);
      repeat (24) begin
         pulse(i_cmd_clk_fall);
         tick(1);
      end
   endtask
   initial begin
      logic [5:0] a, s;
      logic [3:0] kd;
      tick(6);
      i_resetn = 1;
      tick(1);
      chk("nvm", 1, o_nvm_reload);
      tick(1);
      chk("spi", 1, o_spi_en);
      chk("up", 1, o_up_port_en);
      chk("down", 0, o_down_port_en);
      chk("tag", 1, o_tag_results);
      chk("filt", 0, o_adc_filter_en);
      foreach (rows[r]) begin
         {a, s, kd} = rows[r];
         send(a, s);
         sync();
         if (kd == 4'h0) begin
            tick(10);
            chk("busy", 0, o_scan_busy);
         end else begin
            await(0);
            chk("kind", kd, o_scan_kind);
            if (kd == 4'h7) chk("elem", s, o_meas_elem);
            await(1);
            chk("pwr", 2, o_power_state);
         end
      end
      send(6'h01, 6'h00);
      await(0);
      send(6'h02, 6'h00);
      await(2);
      send(6'h3f, 6'h00);
      await(4);
      chk("busy", 1, o_scan_busy);
      await(1);
      tick(5);
      chk("busy", 0, o_scan_busy);
      send(6'h06, 6'h00);
      await(0);
      chk("cont", 1, o_cont_scan);
      await(1);
      await(0);
      chk("kind", 6, o_scan_kind);
      pulse(i_scan_inhibit);
      await(1);
      tick(12);
      chk("cont", 0, o_cont_scan);
      chk("busy", 0, o_scan_busy);
      chk("fwd", sent, 8'(taken));
      pulse(i_sleep_cmd);
      chk("pwr", 1, o_power_state);
      pulse(i_comm_wake);
      chk("pwr", 2, o_power_state);
      pulse(i_wdog_expire);
      chk("pwr", 1, o_power_state);
      i_enable = 0;
      tick(1);
      chk("pwr", 0, o_power_state);
      chk("core", 1, o_core_en);
      i_enable = 1;
      tick(1);
      chk("pwr", 2, o_power_state);
      chk("nvm", 0, o_nvm_reload);
      tally_and_finish();
   end
endmodule
